// ===== design/lpes_pkg.sv
// Package for the second-level cache performance event selector
package lpes_pkg;

  // Register byte offsets
  localparam logic [7:0] LPES_CTRL_OFS   = 8'h00;
  localparam logic [7:0] LPES_COUNT_OFS  = 8'h04;
  localparam logic [7:0] LPES_STATUS_OFS = 8'h08;

  // Control register fields
  localparam int LPES_EVT_LSB   = 0;
  localparam int LPES_UMASK_LSB = 8;
  localparam int LPES_EN_BIT    = 16;
  localparam logic [31:0] LPES_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] LPES_COUNT_RST = 32'h0000_0000;

  // Event numbers
  localparam logic [7:0] LPES_EV_LOCK  = 8'h2B;
  localparam logic [7:0] LPES_EV_RQSTS = 8'h2E;
  localparam logic [7:0] LPES_EV_REJ   = 8'h30;
  localparam logic [7:0] LPES_EV_IDLE  = 8'h32;
  localparam logic [7:0] LPES_EV_TRANS = 8'h3A;

  // Fixed architectural unit masks of the request and transition events
  localparam logic [7:0] LPES_UM_DEM_MISS = 8'h41;
  localparam logic [7:0] LPES_UM_DEM_ALL  = 8'h4F;
  localparam logic [7:0] LPES_UM_NONE     = 8'h00;

  // Unit-mask subfields: core [7:6], prefetch [5:4], line state [3:0]
  localparam int LPES_CORE_MSB  = 7;
  localparam int LPES_CORE_LSB  = 6;
  localparam int LPES_PF_MSB    = 5;
  localparam int LPES_PF_LSB    = 4;
  localparam int LPES_STATE_MSB = 3;
  localparam logic [1:0] LPES_CORE_BOTH = 2'h3;
  localparam logic [1:0] LPES_PF_ALL    = 2'h3;
  localparam logic [1:0] LPES_PF_HW     = 2'h1;
  localparam logic [1:0] LPES_PF_DEMAND = 2'h0;

  // Line state index, one bit per state in the state mask
  typedef enum logic [1:0] {
    LPES_ST_I = 2'h0,
    LPES_ST_S = 2'h1,
    LPES_ST_E = 2'h2,
    LPES_ST_M = 2'h3
  } lpes_state_t;

  // AHB transfer type
  localparam logic [1:0] LPES_HTRANS_NONSEQ = 2'h2;

  // Per-core event sources, one cycle each
  typedef struct packed {
    logic        lock_v;     // Locked access missing first-level cache
    lpes_state_t lock_st;
    logic        rqst_v;     // Completed second-level request
    logic        rqst_hwpf;  // Request came from hardware prefetcher
    logic        rqst_hit;   // Request hit the second-level cache
    lpes_state_t rqst_st;
    logic        busq_v;     // Pending request wants the bus queue
    logic        busq_hwpf;
    lpes_state_t busq_st;
    logic        pend;       // Any second-level request pending
  } lpes_core_ev_t;

  // Power-state event sources
  typedef struct packed {
    logic freq_chg;          // Frequency change, any voltage
    logic throttle;          // Thermal throttle transition
    logic active;            // Core in active execution state
  } lpes_pwr_ev_t;

endpackage

// ===== design/lpes_selector.sv
// Second-level cache performance event selector with AHB-Lite registers
// Contract
// [R1] Event 2BH counts each locked access that missed the first-level data cache.
// [R2] The core subfield of the unit mask selects the own core alone or both cores.
// [R3] Lock, request and rejection events count only lines in states set in the state mask.
// [R4] Event 2EH counts every completed second-level request from all listed sources.
// [R5] Request and rejection events count demand, prefetch or both as the mask chooses.
// [R6] Event 2EH mask 41H counts own-core demand requests that miss, no prefetches.
// [R7] Event 2EH mask 4FH counts every own-core demand request, hit or miss.
// [R8] Masks 41H and 4FH are decoded as fixed encodings independent of the subfields.
// [R9] Event 30H counts when a pending bus-bound request is held out of the bus queue.
// [R10] A rejection arises from a full bus queue or a queue entry in the same set.
// [R11] A rejected request counts once per rejected cycle, so repeats add again.
// [R12] Event 32H counts each cycle with no pending request on the own core.
// [R13] With both cores selected, event 32H counts only when neither core is pending.
// [R14] Event 32H keeps counting while one core is halted and the other runs.
// [R15] Event 3AH counts each frequency-changing transition, throttling included.
// [R16] Event 3AH counts only while the core is in its active execution state.
// [R17] Event and mask are compared every cycle and give a one-cycle increment pulse.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
module lpes_selector
  import lpes_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic                ref_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ce_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o,
  input  wire lpes_pkg::lpes_core_ev_t [1:0] core_ev_i,
  input  wire lpes_pkg::lpes_pwr_ev_t        pwr_ev_i,
  input  wire logic                busq_full_i,
  input  wire logic                busq_set_hit_i,
  output logic                     inc_o,
  output logic [1:0]               inc_cnt_o
);
  import lpes_pkg::*;

  // Register state
  logic [31:0]      ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic             inc_q;
  logic [1:0]       inc_cnt_q;
  logic             supp_q;

  // Bus data-phase state
  logic             wr_pend_q;
  logic [7:0]       wr_ofs_q;
  logic [31:0]      rdata_q;

  // Decode of the programmed selection
  logic [7:0]       evt_sel;
  logic [7:0]       umask;
  logic             cnt_en;
  logic             both_core;
  logic [1:0]       pf_sel;
  logic [3:0]       st_mask;

  // Per-core qualified hits and the final selection
  logic [1:0]       lock_hit;
  logic [1:0]       rqst_hit;
  logic [1:0]       rej_hit;
  logic [1:0]       core_used;
  logic [1:0]       hit_vec;
  logic             idle_hit;
  logic             trans_hit;
  logic             supp_d;
  logic [1:0]       inc_cnt_d;

  assign evt_sel   = ctrl_q[LPES_EVT_LSB +: 8];
  assign umask     = ctrl_q[LPES_UMASK_LSB +: 8];
  assign cnt_en    = ctrl_q[LPES_EN_BIT];
  assign both_core = (umask[LPES_CORE_MSB:LPES_CORE_LSB] == LPES_CORE_BOTH);
  assign pf_sel    = umask[LPES_PF_MSB:LPES_PF_LSB];
  assign st_mask   = umask[LPES_STATE_MSB:0];

  // Own core is index 0; the other core joins only with the both-cores mask
  // [R2] core qualifier
  assign core_used = {both_core, 1'b1};

  // Line-state filter: one mask bit per coherence state
  function automatic logic st_ok(input lpes_state_t st, input logic [3:0] msk);
    st_ok = msk[st];
  endfunction

  // Demand/prefetch filter; the unused encoding counts nothing
  function automatic logic pf_ok(input logic hwpf, input logic [1:0] sel);
    case (sel)
      LPES_PF_ALL:    pf_ok = 1'b1;
      LPES_PF_HW:     pf_ok = hwpf;
      LPES_PF_DEMAND: pf_ok = ~hwpf;
      default:        pf_ok = 1'b0;
    endcase
  endfunction

  // Per-core qualification of the cache events
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // [R1] locked first-level miss
      // [R3] state filter on locks
      lock_hit[c] = core_used[c] & core_ev_i[c].lock_v &
                    st_ok(core_ev_i[c].lock_st, st_mask);
      // [R4] completed requests counted
      // [R5] demand/prefetch split
      rqst_hit[c] = core_used[c] & core_ev_i[c].rqst_v &
                    pf_ok(core_ev_i[c].rqst_hwpf, pf_sel) &
                    st_ok(core_ev_i[c].rqst_st, st_mask);
      // [R9] held back from bus queue
      // [R10] full queue or set conflict
      // [R11] every rejected cycle counts
      rej_hit[c]  = core_used[c] & core_ev_i[c].busq_v &
                    (busq_full_i | busq_set_hit_i) &
                    pf_ok(core_ev_i[c].busq_hwpf, pf_sel) &
                    st_ok(core_ev_i[c].busq_st, st_mask);
    end
  end

  // Idle cycles look only at pending flags, never at halt state
  // [R12] own core idle
  // [R13] both cores idle
  // [R14] halt does not gate
  assign idle_hit = ~core_ev_i[0].pend & ~(both_core & core_ev_i[1].pend);

  // Frequency transitions, throttling included, only while active
  // [R15] frequency-changing transitions
  // [R16] active state only
  assign trans_hit = (pwr_ev_i.freq_chg | pwr_ev_i.throttle) & pwr_ev_i.active;

  // Event routing; lock, request and rejection events may fire for both cores at once
  // [R17] compare and route
  always_comb begin
    hit_vec = 2'h0;
    supp_d  = 1'b1;
    case (evt_sel)
      LPES_EV_LOCK: begin
        hit_vec = lock_hit;
      end
      LPES_EV_RQSTS: begin
        // [R8] fixed architectural masks
        if (umask == LPES_UM_DEM_MISS) begin
          // [R6] own demand misses
          hit_vec = {1'b0, core_ev_i[0].rqst_v & ~core_ev_i[0].rqst_hwpf &
                           ~core_ev_i[0].rqst_hit};
        end else if (umask == LPES_UM_DEM_ALL) begin
          // [R7] own demand, hit or miss
          hit_vec = {1'b0, core_ev_i[0].rqst_v & ~core_ev_i[0].rqst_hwpf};
        end else begin
          hit_vec = rqst_hit;
        end
      end
      LPES_EV_REJ: begin
        hit_vec = rej_hit;
      end
      LPES_EV_IDLE: begin
        hit_vec = {1'b0, idle_hit};
      end
      LPES_EV_TRANS: begin
        if (umask == LPES_UM_NONE) begin
          hit_vec = {1'b0, trans_hit};
        end else begin
          supp_d = 1'b0;
        end
      end
      default: begin
        supp_d = 1'b0;
      end
    endcase
  end

  // Add the two core hits; disabled selection gives no increments
  assign inc_cnt_d = cnt_en ? ({1'b0, hit_vec[0]} + {1'b0, hit_vec[1]}) : 2'h0;

  // Registered increment pulse, one cycle per qualifying cycle
  // [R17] one-cycle pulse
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      inc_q     <= 1'b0;
      inc_cnt_q <= 2'h0;
      supp_q    <= 1'b0;
    end else if (ce_i) begin
      inc_q     <= (inc_cnt_d != 2'h0);
      inc_cnt_q <= inc_cnt_d;
      supp_q    <= supp_d;
    end
  end

  assign inc_o     = inc_q;
  assign inc_cnt_o = inc_cnt_q;

  // Bus handshake: zero wait states, stalled only while frozen
  logic addr_ph;
  assign addr_ph     = hsel_i & hready_i & (htrans_i == LPES_HTRANS_NONSEQ);
  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;

  // Read mux for the address phase; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr_i[7:0])
      LPES_CTRL_OFS:   rd_mux = ctrl_q;
      LPES_COUNT_OFS:  rd_mux = 32'(count_q);
      LPES_STATUS_OFS: rd_mux = {28'h0, core_ev_i[1].pend, core_ev_i[0].pend,
                                 supp_q, inc_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
    if (haddr_i[31:8] != 24'h0) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Address phase capture; read data is latched here so it is a flop output
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend_q <= addr_ph & hwrite_i & (haddr_i[31:8] == 24'h0);
      wr_ofs_q  <= haddr_i[7:0];
      if (addr_ph && !hwrite_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= LPES_CTRL_RST;
    end else if (ce_i && wr_pend_q && wr_ofs_q == LPES_CTRL_OFS) begin
      ctrl_q <= {15'h0, hwdata_i[16:0]};
    end
  end

  // Counter; a write in the same cycle as a count keeps the increment
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      count_q <= CNT_W'(LPES_COUNT_RST);
    end else if (ce_i) begin
      if (wr_pend_q && wr_ofs_q == LPES_COUNT_OFS) begin
        count_q <= CNT_W'(hwdata_i) + CNT_W'(inc_cnt_q);
      end else begin
        count_q <= count_q + CNT_W'(inc_cnt_q);
      end
    end
  end

  // Unused bus fields: only whole-word singles are expected
  logic unused_ok;
  assign unused_ok = ^{hsize_i, haddr_i[1:0]};

endmodule

// ===== dv/lpes_sel_chk.sv
// Port-level assertions for the event selector
module lpes_sel_chk
  import lpes_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire lpes_pkg::lpes_core_ev_t [1:0] core_ev_i,
  input wire lpes_pkg::lpes_pwr_ev_t pwr_ev_i,
  input wire logic busq_full_i,
  input wire logic busq_set_hit_i,
  input wire logic inc_o,
  input wire logic [1:0] inc_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_inc_count: assert property (inc_o == (inc_cnt_o != 2'h0))
    else $error("increment pulse and count disagree");
  // at most one count per core
  chk_cnt_max: assert property (inc_cnt_o != 2'h3)
    else $error("increment count above two");
  // a double count needs the other core active
  chk_pair_src: assert property ($past(ce_i) && inc_cnt_o == 2'h2 |->
    $past(core_ev_i[1].lock_v | core_ev_i[1].rqst_v | core_ev_i[1].busq_v))
    else $error("double count without other core event");
  // bus answers are always okay and ready follows enable
  chk_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  chk_ready_ce: assert property (hreadyout_o == ce_i)
    else $error("ready does not follow clock enable");
  // a stopped clock enable freezes the increment count and read data
  chk_ce_freeze: assert property (!ce_i |=> $stable(inc_cnt_o) && $stable(hrdata_o))
    else $error("outputs moved while frozen");
  // read data only changes after a taken read
  chk_rdata_hold: assert property (!(ce_i && hsel_i && hready_i && !hwrite_i &&
    htrans_i == LPES_HTRANS_NONSEQ) |=> $stable(hrdata_o))
    else $error("read data changed without a read");
  // reset clears the increment and read data
  chk_reset_quiet: assert property (disable iff (1'b0) !resetn_i && ce_i |=>
    !inc_o && hrdata_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule

bind lpes_selector lpes_sel_chk u_chk (.*);

// ===== dv/lpes_selector_tb.sv
// Self-checking bench for the event selector
module lpes_selector_tb import lpes_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam lpes_core_ev_t Q = lpes_core_ev_t'(13'h0001);
  logic ref_clk_i = 0, resetn_i = 0, ce_i = 1, hsel_i = 0, hwrite_i = 0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o;
  logic [1:0] htrans_i = '0, inc_cnt_o;
  logic [2:0] hsize_i = 3'h2;
  logic hready_i, hreadyout_o, hresp_o, inc_o, busq_full_i, busq_set_hit_i;
  lpes_core_ev_t [1:0] core_ev_i;
  lpes_pwr_ev_t pwr_ev_i;
  int n_mismatch = 0, check_count = 0;
  // Single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;
  lpes_selector uut (.*);
  lpes_src_model src (.ref_clk_i, .core_ev_o(core_ev_i), .pwr_ev_o(pwr_ev_i), .full_o(busq_full_i),
    .set_hit_o(busq_set_hit_i));
  // Single word transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk_i);
    {hsel_i, hwrite_i, htrans_i, haddr_i} <= {1'b1, w, LPES_HTRANS_NONSEQ, 24'h0, a};
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    {hsel_i, htrans_i, hwdata_i} <= {3'h0, wd};
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Select, clear the count, play four cycles of sources, read the count back
  task automatic meas(input logic [31:0] c, input lpes_core_ev_t e0, e1, input logic [4:0] x, input logic [31:0] ex);
    logic [31:0] rd;
    bus(1, LPES_CTRL_OFS, c, rd);
    bus(1, LPES_COUNT_OFS, 32'h0, rd);
    src.play(e0, e1, x, 4);
    repeat (3) @(posedge ref_clk_i);
    bus(0, LPES_COUNT_OFS, 32'h0, rd);
    chk("count", ex, rd);
  endtask
  task automatic t_regs;
    logic [31:0] rd;
    bus(0, LPES_CTRL_OFS, 32'h0, rd);
    chk("ctrl", LPES_CTRL_RST, rd);
    bus(0, LPES_COUNT_OFS, 32'h0, rd);
    chk("count", LPES_COUNT_RST, rd);
    bus(1, 8'h10, 32'hFFFF_FFFF, rd);
    bus(0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1, LPES_CTRL_OFS, 32'h0001_002C, rd);
    bus(1, LPES_STATUS_OFS, 32'h0000_000F, rd);
    bus(0, LPES_STATUS_OFS, 32'h0, rd);
    chk("status", 32'h0000_000C, rd);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("frozen ready", 32'h0, {31'h0, hreadyout_o});
    chk("response", 32'h0, {31'h0, hresp_o});
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
  endtask
  // One cycle of locks on both cores: pulse shows a count of two for one cycle only
  task automatic t_pulse;
    logic [31:0] rd;
    bus(1, LPES_CTRL_OFS, 32'h0001_C82B, rd);
    fork
      src.play(src.ev(1, 3, 0, 0, 1), src.ev(1, 3, 0, 0, 1), 0, 1);
      begin
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("pulse count", 32'h2, {30'h0, inc_cnt_o});
        chk("pulse", 32'h1, {31'h0, inc_o});
        @(posedge ref_clk_i);
        #1;
        chk("pulse end", 32'h0, {31'h0, inc_o});
      end
    join
    bus(0, LPES_STATUS_OFS, 32'h0, rd);
    chk("supported", 32'h2, rd & 32'h0000_0002);
  endtask
  task automatic t_lock;
    meas(32'h0001_082B, src.ev(1, 3, 0, 0, 1), src.ev(1, 3, 0, 0, 1), 0, 4);
    meas(32'h0001_C82B, src.ev(1, 3, 0, 0, 1), src.ev(1, 3, 0, 0, 1), 0, 8);
    meas(32'h0001_082B, src.ev(1, 1, 0, 0, 1), Q, 0, 0);
    meas(32'h0000_082B, src.ev(1, 3, 0, 0, 1), Q, 0, 0);
  endtask
  task automatic t_rqst;
    meas(32'h0001_4F2E, src.ev(2, 3, 0, 1, 1), src.ev(2, 3, 0, 1, 1), 0, 4);
    meas(32'h0001_4F2E, src.ev(2, 3, 1, 1, 1), Q, 0, 0);
    meas(32'h0001_412E, src.ev(2, 0, 0, 0, 1), Q, 0, 4);
    meas(32'h0001_412E, src.ev(2, 3, 0, 1, 1), Q, 0, 0);
    meas(32'h0001_1F2E, src.ev(2, 3, 1, 1, 1), Q, 0, 4);
    meas(32'h0001_1F2E, src.ev(2, 3, 0, 1, 1), Q, 0, 0);
    meas(32'h0001_3F2E, src.ev(2, 3, 0, 1, 1), Q, 0, 4);
  endtask
  task automatic t_rej;
    meas(32'h0001_3F30, src.ev(4, 3, 0, 0, 1), Q, 5'h02, 4);
    meas(32'h0001_3F30, src.ev(4, 3, 0, 0, 1), Q, 5'h01, 4);
    meas(32'h0001_3F30, src.ev(4, 3, 0, 0, 1), Q, 5'h00, 0);
  endtask
  task automatic t_idle;
    meas(32'h0001_0032, src.ev(0, 0, 0, 0, 0), Q, 0, 4);
    meas(32'h0001_C032, src.ev(0, 0, 0, 0, 0), Q, 0, 0);
    meas(32'h0001_C032, src.ev(0, 0, 0, 0, 0), src.ev(0, 0, 0, 0, 0), 0, 4);
  endtask
  task automatic t_trans;
    meas(32'h0001_003A, Q, Q, 5'h14, 4);
    meas(32'h0001_003A, Q, Q, 5'h0C, 4);
    meas(32'h0001_003A, Q, Q, 5'h10, 0);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Free-running core clock
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_lock();
    t_pulse();
    t_rqst();
    t_rej();
    t_idle();
    t_trans();
    tally_and_finish();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

// ===== dv/lpes_src_model.sv
// Behavioural cache, bus-queue and power-state event sources
module lpes_src_model
  import lpes_pkg::*;
(
  input  wire logic                    ref_clk_i,
  output lpes_pkg::lpes_core_ev_t [1:0] core_ev_o,
  output lpes_pkg::lpes_pwr_ev_t       pwr_ev_o,
  output logic                         full_o,
  output logic                         set_hit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet cores keep a request pending so idle cycles never count by accident
  localparam lpes_core_ev_t QUIET = lpes_core_ev_t'(13'h0001);
  initial begin
    core_ev_o = {QUIET, QUIET};
    pwr_ev_o = lpes_pwr_ev_t'(3'h0);
    {full_o, set_hit_o} = 2'h0;
  end
  // Build one core's sources: v is {busq, rqst, lock}, one line state for all
  function automatic lpes_core_ev_t ev(input logic [2:0] v, input logic [1:0] st, input logic hw, hit, p);
    return lpes_core_ev_t'({v[0], st, v[1], hw, hit, st, v[2], hw, st, p});
  endfunction
  // Hold a pattern for n cycles after an edge, then fall quiet
  task automatic play(input lpes_core_ev_t e0, e1, input logic [4:0] x, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      core_ev_o <= {e1, e0};
      pwr_ev_o <= lpes_pwr_ev_t'(x[4:2]);
      // queue full and same-set hold-back sources
      {full_o, set_hit_o} <= x[1:0];
    end
    @(posedge ref_clk_i);
    core_ev_o <= {QUIET, QUIET};
    pwr_ev_o <= lpes_pwr_ev_t'(3'h0);
    {full_o, set_hit_o} <= 2'h0;
  endtask
endmodule
